// ==== hdl/acb_pkg.sv ====
// acb_pkg: constants and carriers for the add/and/branch execution datapath
// assumes a single 50 MHz instruction clock, four phases per cycle
package acb_pkg;
  // ----------------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_LIT = 8'h0f;
  localparam logic [7:0] OPC_AND_LIT = 8'h0b;
  localparam logic [7:0] OPC_BR_CARRY = 8'he2;
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;
  localparam logic [5:0] OPC_ADDC_FILE = 6'h08;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [3:0] FAST_BANK = 4'h0;

  // one-hot phase of the instruction cycle
  typedef enum logic [3:0] {
    ACB_PH_DECODE = 4'b0001,
    ACB_PH_READ = 4'b0010,
    ACB_PH_PROC = 4'b0100,
    ACB_PH_WRITE = 4'b1000
  } acb_phase_t;

  // data memory request towards the file store
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } acb_mem_req_t;
endpackage

// ==== hdl/acb_exec.sv ====
// acb_exec: execution datapath for add, add-with-carry, and, branch-on-carry
// assumes instr_in is held stable for a whole instruction cycle and mem_rdata
// answers a read in the same phase in which the read is issued
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
`timescale 1ns/1ps
module acb_exec (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // instruction and bank
  input wire logic [15:0] instr_in,
  input wire logic [3:0] bank_select_in,
  // data memory
  output acb_pkg::acb_mem_req_t mem_req_out,
  input wire logic [7:0] mem_rdata_in,
  // state
  output logic [7:0] acc_out,
  output logic [4:0] flags_out,
  output logic [20:0] pc_out,
  output acb_pkg::acb_phase_t phase_out,
  output logic fetch_out,
  output logic stall_out
);
  import acb_pkg::*;

  typedef enum logic [2:0] {
    ACB_OP_NONE = 3'h0,
    ACB_OP_ADD = 3'h1,
    ACB_OP_ADDC = 3'h2,
    ACB_OP_AND = 3'h3,
    ACB_OP_BC = 3'h4
  } acb_op_t;

  acb_phase_t phase_q;
  acb_op_t op_q;
  logic lit_q;
  logic dest_q;
  logic [11:0] addr_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic [4:0] nflags_q;
  logic flag_wr_all_q;
  logic idle_q;
  logic take_q;
  logic [7:0] acc_q;
  logic [4:0] flags_q;
  logic [20:0] pc_q;
  logic [7:0] wdata_q;
  logic rd_q;
  logic wr_q;
  logic [10:0] alu_sum;
  logic [7:0] alu_res;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // returns {c, dc, ov, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] lo;
    logic ov;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {s[8], lo[4], ov, s[7:0]};
  endfunction

  function automatic logic [20:0] br_target(input logic [20:0] pc,
                                            input logic [7:0] n);
    logic [20:0] off;
    off = {{12{n[7]}}, n, 1'b0};
    return pc + PC_STEP + off;
  endfunction

  // only file-register words touch data memory
  function automatic logic is_file_op(input logic [15:0] w);
    return w[15:10] == OPC_ADD_FILE || w[15:10] == OPC_ADDC_FILE ||
           w[15:10] == OPC_AND_FILE;
  endfunction

  // one alu shared by the result register and the memory write data
  always_comb begin
    alu_sum = add8(acc_q, opnd_q, op_q == ACB_OP_ADDC && flags_q[FLAG_C]);
    alu_res = (op_q == ACB_OP_AND) ? (acc_q & opnd_q) : alu_sum[7:0];
  end

  // ----------------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_q <= ACB_PH_DECODE;
    end else begin
      case (phase_q)
        ACB_PH_DECODE: phase_q <= ACB_PH_READ;
        ACB_PH_READ: phase_q <= ACB_PH_PROC;
        ACB_PH_PROC: phase_q <= ACB_PH_WRITE;
        ACB_PH_WRITE: phase_q <= ACB_PH_DECODE;
        default: phase_q <= ACB_PH_DECODE;
      endcase
    end
  end

  // idle cycle after a taken branch; the fetched word is discarded
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_q <= 1'b0;
    end else if (phase_q == ACB_PH_WRITE) begin
      idle_q <= !idle_q && op_q == ACB_OP_BC && take_q;
    end
  end

  // ----------------------------------------------------------------------
  // decode (first phase)
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_q <= ACB_OP_NONE;
      lit_q <= 1'b0;
      dest_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (phase_q == ACB_PH_DECODE) begin
      lit_q <= 1'b0;
      dest_q <= instr_in[DEST_BIT];
      addr_q <= {instr_in[BANK_BIT] ? bank_select_in : FAST_BANK,
                 instr_in[7:0]};
      if (idle_q) begin
        op_q <= ACB_OP_NONE;
      end else if (instr_in[15:8] == OPC_ADD_LIT) begin
        op_q <= ACB_OP_ADD;
        lit_q <= 1'b1;
      end else if (instr_in[15:8] == OPC_AND_LIT) begin
        op_q <= ACB_OP_AND;
        lit_q <= 1'b1;
      end else if (instr_in[15:8] == OPC_BR_CARRY) begin
        op_q <= ACB_OP_BC;
      end else if (instr_in[15:10] == OPC_ADD_FILE) begin
        op_q <= ACB_OP_ADD;
      end else if (instr_in[15:10] == OPC_ADDC_FILE) begin
        op_q <= ACB_OP_ADDC;
      end else if (instr_in[15:10] == OPC_AND_FILE) begin
        op_q <= ACB_OP_AND;
      end else begin
        op_q <= ACB_OP_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // operand read (second phase); literal comes from instr_in, held stable
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= phase_q == ACB_PH_DECODE && !idle_q && is_file_op(instr_in);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      opnd_q <= 8'h00;
    end else if (phase_q == ACB_PH_READ) begin
      opnd_q <= (lit_q || op_q == ACB_OP_BC) ? instr_in[7:0] : mem_rdata_in;
    end
  end

  // ----------------------------------------------------------------------
  // processing (third phase)
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      res_q <= 8'h00;
      nflags_q <= FLAGS_RST;
      flag_wr_all_q <= 1'b0;
      take_q <= 1'b0;
    end else if (phase_q == ACB_PH_PROC) begin
      res_q <= alu_res;
      flag_wr_all_q <= op_q == ACB_OP_ADD || op_q == ACB_OP_ADDC;
      nflags_q[FLAG_C] <= alu_sum[10];
      nflags_q[FLAG_DC] <= alu_sum[9];
      nflags_q[FLAG_OV] <= alu_sum[8];
      nflags_q[FLAG_N] <= alu_res[7];
      nflags_q[FLAG_Z] <= alu_res == 8'h00;
      take_q <= op_q == ACB_OP_BC && flags_q[FLAG_C];
    end
  end

  // ----------------------------------------------------------------------
  // write back (fourth phase)
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_q <= ACC_RST;
    end else if (phase_q == ACB_PH_WRITE && op_q != ACB_OP_NONE &&
                 op_q != ACB_OP_BC && (lit_q || !dest_q)) begin
      acc_q <= res_q;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      wr_q <= phase_q == ACB_PH_PROC && !lit_q && dest_q &&
              (op_q == ACB_OP_ADD || op_q == ACB_OP_ADDC ||
               op_q == ACB_OP_AND);
      if (phase_q == ACB_PH_PROC) begin
        wdata_q <= alu_res;
      end
    end
  end

  // carry, half carry and wrap only move for the adds
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_q <= FLAGS_RST;
    end else if (phase_q == ACB_PH_WRITE) begin
      if (flag_wr_all_q) begin
        flags_q <= nflags_q;
      end else if (op_q == ACB_OP_AND) begin
        flags_q[FLAG_N] <= nflags_q[FLAG_N];
        flags_q[FLAG_Z] <= nflags_q[FLAG_Z];
      end
    end
  end

  // pc always points at the word under execution
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_q <= PC_RST;
    end else if (phase_q == ACB_PH_WRITE) begin
      if (op_q == ACB_OP_BC && take_q) begin
        pc_q <= br_target(pc_q, opnd_q);
      end else if (!idle_q) begin
        pc_q <= pc_q + PC_STEP;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign mem_req_out = '{rd: rd_q, wr: wr_q, addr: addr_q, wdata: wdata_q};
  assign acc_out = acc_q;
  assign flags_out = flags_q;
  assign pc_out = pc_q;
  assign phase_out = phase_q;
  assign fetch_out = phase_q == ACB_PH_WRITE;
  assign stall_out = idle_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_PHASE_ROTATE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_DECODE |=> phase_q == ACB_PH_READ ##1
      phase_q == ACB_PH_PROC ##1 phase_q == ACB_PH_WRITE)
    else $error("phase sequence broken");
  AST_AND_KEEPS_C: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && op_q == ACB_OP_AND |=>
      $stable(flags_q[FLAG_C]) && $stable(flags_q[FLAG_OV]) &&
      $stable(flags_q[FLAG_DC]))
    else $error("and changed arithmetic flags");
  AST_BC_NO_FLAGS: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && op_q == ACB_OP_BC |=> $stable(flags_q))
    else $error("branch changed flags");
  AST_BC_TARGET: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && op_q == ACB_OP_BC && take_q |=>
      pc_q == $past(pc_q) + PC_STEP +
        {{12{$past(opnd_q[7])}}, $past(opnd_q), 1'b0})
    else $error("branch target wrong");
  AST_BC_IDLE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && op_q == ACB_OP_BC && take_q |=>
      ##1 op_q == ACB_OP_NONE [*4])
    else $error("idle cycle executed work");
  AST_ZERO_FLAG: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && flag_wr_all_q |=>
      flags_q[FLAG_Z] == (acc_q == 8'h00 && $past(!dest_q || lit_q))
      || $past(dest_q && !lit_q))
    else $error("zero flag mismatch");
  AST_ACC_DEST: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_WRITE && !lit_q && dest_q |=> $stable(acc_q))
    else $error("accumulator written with dest 1");
  AST_WR_DEST: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_q |-> phase_q == ACB_PH_WRITE && dest_q && !lit_q)
    else $error("memory write outside write phase");
  AST_FAST_BANK: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    phase_q == ACB_PH_DECODE && !instr_in[BANK_BIT] |=>
      addr_q[11:8] == FAST_BANK)
    else $error("fast bank not used");
  AST_RD_FILE_ONLY: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    rd_q |-> phase_q == ACB_PH_READ && !lit_q &&
      (op_q == ACB_OP_ADD || op_q == ACB_OP_ADDC || op_q == ACB_OP_AND))
    else $error("operand read for a non-file word");
endmodule // acb_exec

// ==== bench/test_add_and_carry_branch_exec.sv ====
// test_add_and_carry_branch_exec: self-checking bench for acb_exec
// assumes the design carries its own assertions; the bench drives every port
`timescale 1ns/1ps
module test_add_and_carry_branch_exec;
  import acb_pkg::*;
  // ----------------------------------------------------------------------
  // signals and expected state
  // ----------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] instr_in = 16'h0000;
  logic [3:0] bank_select_in = 4'h0;
  logic [7:0] mem_rdata_in = 8'h00;
  acb_mem_req_t mem_req_out;
  logic [7:0] acc_out;
  logic [4:0] flags_out;
  logic [20:0] pc_out;
  acb_phase_t phase_out;
  logic fetch_out;
  logic stall_out;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] e_acc = ACC_RST;
  logic [4:0] e_fl = FLAGS_RST;
  logic [20:0] e_pc = PC_RST;

  acb_exec u_dut (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .instr_in(instr_in),
    .bank_select_in(bank_select_in),
    .mem_req_out(mem_req_out),
    .mem_rdata_in(mem_rdata_in),
    .acc_out(acc_out),
    .flags_out(flags_out),
    .pc_out(pc_out),
    .phase_out(phase_out),
    .fetch_out(fetch_out),
    .stall_out(stall_out)
  );

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one instruction, then a no-op so the word can change safely
  task automatic exec(input logic [15:0] i, input logic [3:0] bsel,
                      input logic [7:0] r);
    logic file, lit, taken, ci;
    logic [7:0] a, b, res;
    logic [8:0] s;
    logic [4:0] h;
    logic [11:0] addr;
    a = e_acc;
    ci = e_fl[FLAG_C];
    file = i[15:10] inside {OPC_ADD_FILE, OPC_ADDC_FILE, OPC_AND_FILE};
    lit = i[15:8] inside {OPC_ADD_LIT, OPC_AND_LIT};
    b = file ? r : i[7:0];
    addr = {i[BANK_BIT] ? bsel : FAST_BANK, i[7:0]};
    taken = (i[15:8] == OPC_BR_CARRY) && ci;
    if (i[15:10] != OPC_ADDC_FILE) ci = 1'b0;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    res = s[7:0];
    if (i[15:8] == OPC_AND_LIT || i[15:10] == OPC_AND_FILE) begin
      res = a & b;
      e_fl[FLAG_N] = res[7];
      e_fl[FLAG_Z] = (res == 8'h00);
    end else if (lit || file) begin
      e_fl = {res[7], (a[7] == b[7]) && (res[7] != a[7]), res == 8'h00,
              h[4], s[8]};
    end
    if ((lit || file) && !(file && i[DEST_BIT])) e_acc = res;
    e_pc = taken ? e_pc + 21'h000002 + {{12{b[7]}}, b, 1'b0}
                 : e_pc + PC_STEP;
    @(posedge clk_in);
    bank_select_in <= bsel;
    instr_in <= i;
    mem_rdata_in <= r;
    @(posedge clk_in);
    #1;
    chk(phase_out, ACB_PH_READ, "phase read");
    chk(fetch_out, 1'b0, "no fetch in read");
    chk(mem_req_out.rd, file, "rd");
    if (file) chk(mem_req_out.addr, addr, "addr");
    repeat (2) @(posedge clk_in);
    #1;
    chk(fetch_out, 1'b1, "fetch");
    chk(mem_req_out.wr, file && i[DEST_BIT], "wr");
    if (file && i[DEST_BIT]) chk(mem_req_out.wdata, res, "wdata");
    @(posedge clk_in);
    instr_in <= 16'h0000;
    #1;
    chk(acc_out, e_acc, "acc");
    chk(flags_out, e_fl, "flags");
    chk(pc_out, e_pc, "pc");
    chk(stall_out, taken, "stall");
    if (taken) begin
      repeat (4) @(posedge clk_in);
      #1;
      chk(pc_out, e_pc, "idle pc");
      chk(acc_out, e_acc, "idle acc");
      chk(stall_out, 1'b0, "stall end");
    end
    e_pc = e_pc + PC_STEP;
    repeat (3) @(posedge clk_in);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic sc_add_lit();
    exec(16'h0f10, 4'h0, 8'h00);
    exec(16'h0f15, 4'h0, 8'h00);
    exec(16'h0fdb, 4'h0, 8'h00);
  endtask

  // carry survives an and, then both offset extremes and a fall-through
  task automatic sc_branch();
    exec(16'h0bff, 4'h0, 8'h00);
    exec(16'he27f, 4'h0, 8'h00);
    exec(16'he280, 4'h0, 8'h00);
    exec(16'h0f01, 4'h0, 8'h00);
    exec(16'he205, 4'h0, 8'h00);
  endtask

  task automatic sc_add_file();
    exec(16'h2440, 4'h3, 8'h16);
    exec(16'h2733, 4'ha, 8'hc2);
    exec(16'h0f69, 4'h0, 8'h00);
    exec(16'h0f80, 4'h0, 8'h00);
    exec(16'h2055, 4'h7, 8'hff);
    exec(16'h2312, 4'h5, 8'h4d);
    exec(16'h2001, 4'h0, 8'h02);
  endtask

  // ands with literal adds as setup, then an undefined word that must only step the counter
  task automatic sc_and();
    exec(16'h0f15, 4'h0, 8'h00);
    exec(16'h1411, 4'h6, 8'hc2);
    exec(16'h1722, 4'hf, 8'hfd);
    exec(16'h0fa1, 4'h0, 8'h00);
    exec(16'h0b5f, 4'h0, 8'h00);
    exec(16'hffff, 4'h0, 8'h00);
  endtask

  task automatic sc_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk(acc_out, ACC_RST, "reset acc");
    chk(flags_out, FLAGS_RST, "reset flags");
    chk(pc_out, PC_RST, "reset pc");
    chk(phase_out, ACB_PH_DECODE, "reset phase");
    // release mid-run: the no-op word runs first, as after power-up
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    e_acc = ACC_RST;
    e_fl = FLAGS_RST;
    e_pc = PC_STEP;
    exec(16'h0f15, 4'h0, 8'h00);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // the no-op word on the port runs first after release
    repeat (3) @(posedge clk_in);
    e_pc = PC_STEP;
    sc_add_lit();
    sc_branch();
    sc_add_file();
    sc_and();
    sc_reset();
    wrap_up();
  end

  // about 200 clocks expected; allow ten times that
  initial begin
    #40000;
    n_errors++;
    wrap_up();
  end
endmodule // test_add_and_carry_branch_exec
